// ===== adcct_top.sv
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - setup bits 5 and 4 always read 1, writes ignored.
// - select 00xx none, 01xx inputs 0-3, 10xx inputs 4-7, 11xx prohibited.
// - start by writing 1 to active flag or by trigger edge, which sets it.
// - at end, load result and clear active flag in the same cycle.
// - bit 7 reads busy; write 1 starts, write 0 stops.
// - start register bits 6..0 read 1 and ignore writes.
// - standby control bit 4: 0 standby, 1 run; resets to 1.
// - successive approximation giving a 10-bit result.
// - active flag falling at conversion end sets done request flag.
// - interrupt request raised only while done enable is 1.
// - trigger active only when pin function and trigger enable are 1.
// - result pair keeps contents through reset; undefined at power-on.
// - after end, stay idle until active flag is set again.
// - speed 0 gives 62 clocks, 1 gives 31; keep time at 6.2 us.
// - trigger enable 0 blocks trigger starts; reset value 0.
// - upper 8 result bits in high, lower 2 in low bits 7:6.
// - stored result unchanged until next conversion ends.
module adcct_top
	import adcctl_pkg::*;
#(
	parameter int RES_BITS = RESULT_BITS
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic triggerPin,
	input wire logic compHigh,
	output logic [3:0] inputSelect,
	output logic channelValid,
	output logic sampling,
	output logic [RES_BITS-1:0] dacTrial,
	output logic converterStandby,
	output logic convDoneIrq
);
	initial begin
		if (RES_BITS != RESULT_BITS) $error("adcct_top: result width fixed at 10");
	end

	// ----------------------------------------
	// bus decode
	// ----------------------------------------
	logic wrEn;
	logic rdEn;
	logic rdPhase;
	assign wrEn = psel && penable && pwrite && !pready;
	assign rdPhase = psel && !penable && !pwrite;
	assign rdEn = rdPhase;

	// ----------------------------------------
	// registers
	// ----------------------------------------
	logic speedSelect_reg;
	logic triggerEnable_reg;
	logic [3:0] inputSelect_reg;
	logic conversionActive_reg;
	logic [7:0] clockStop_reg;
	logic triggerEdge_reg;
	logic triggerPinFunc_reg;
	logic doneRequest_reg;
	logic doneIrqEnable_reg;
	logic [RES_BITS-1:0] result_reg;
	logic trigPrev_reg;
	adcct_state_t state_reg;
	logic [5:0] cycleCount_reg;
	logic [5:0] stepCount_reg;

	function automatic logic wr_hit(input logic [11:0] a);
		return wrEn && (paddr == a);
	endfunction

	// 00xx none, 11xx prohibited and treated as none
	function automatic logic select_valid(input logic [3:0] s);
		return s[3] ^ s[2];
	endfunction

	// ----------------------------------------
	// start and stop
	// ----------------------------------------
	logic standbyRun;
	logic trigEdge;
	logic trigArmed;
	logic swStart;
	logic swStop;
	logic anyStart;
	logic convEnd;
	logic [5:0] periodCycles;
	logic [5:0] stepLen;
	logic sarStep;
	logic sarLast;
	logic [RES_BITS-1:0] sarTrial;

	assign standbyRun = clockStop_reg[STOP_STANDBY_BIT];
	// rising edge when edge select is 1, falling when 0
	assign trigEdge = triggerEdge_reg ? (triggerPin && !trigPrev_reg)
		: (!triggerPin && trigPrev_reg);
	assign trigArmed = triggerPinFunc_reg && triggerEnable_reg;
	assign swStart = wr_hit(ADDR_START) && pwdata[START_ACTIVE_BIT];
	assign swStop = wr_hit(ADDR_START) && !pwdata[START_ACTIVE_BIT];
	// one start only, never restarts a running conversion
	assign anyStart = standbyRun && (state_reg == ADCCT_IDLE)
		&& (swStart || (trigArmed && trigEdge));
	assign periodCycles = speedSelect_reg ? 6'(CONV_FAST_CYCLES)
		: 6'(CONV_SLOW_CYCLES);
	// first window samples, then one decision per window; eleven windows (one sample, ten decisions) fit well inside the period
	// so the last decision settles before the result is loaded
	assign stepLen = speedSelect_reg ? 6'd2 : 6'd5;
	assign sarStep = (state_reg == ADCCT_CONV) && (stepCount_reg == stepLen - 6'd1);
	assign convEnd = (state_reg == ADCCT_CONV) && (cycleCount_reg == periodCycles - 6'd1)
		&& !swStop && standbyRun;

	adcct_sar #(
		.WIDTH(RES_BITS)
	) u_sar (
		.clk(clk),
		.reset_n(reset_n),
		.begin_(anyStart),
		.stepEn(sarStep && (cycleCount_reg >= stepLen)),
		.compHigh(compHigh),
		.trial(sarTrial),
		.lastStep(sarLast)
	);

	// ----------------------------------------
	// trigger pin history
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			trigPrev_reg <= 1'b0;
		end else begin
			trigPrev_reg <= triggerPin;
		end
	end

	// ----------------------------------------
	// conversion sequencer
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			state_reg <= ADCCT_IDLE;
			cycleCount_reg <= '0;
			stepCount_reg <= '0;
		end else begin
			case (state_reg)
				ADCCT_IDLE: begin
					cycleCount_reg <= '0;
					stepCount_reg <= '0;
					if (anyStart) begin
						state_reg <= ADCCT_CONV;
					end
				end
				ADCCT_CONV: begin
					cycleCount_reg <= cycleCount_reg + 6'd1;
					stepCount_reg <= (stepCount_reg == stepLen - 6'd1) ? 6'd0
						: stepCount_reg + 6'd1;
					// stop or standby abandons the conversion
					if (convEnd || swStop || !standbyRun) begin
						state_reg <= ADCCT_IDLE;
					end
				end
				default: begin
					state_reg <= ADCCT_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------
	// active flag
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			conversionActive_reg <= 1'b0;
		end else if (anyStart) begin
			conversionActive_reg <= 1'b1;
		end else if (convEnd || swStop || !standbyRun) begin
			conversionActive_reg <= 1'b0;
		end
	end

	// ----------------------------------------
	// result pair, no reset so it survives a system reset
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (convEnd) begin
			result_reg <= sarTrial;
		end
	end

	// ----------------------------------------
	// done request and enable
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			doneRequest_reg <= 1'b0;
		end else if (convEnd) begin
			// set wins over a same-cycle clear
			doneRequest_reg <= 1'b1;
		end else if (wr_hit(ADDR_REQ_FLAGS) && !pwdata[0]) begin
			doneRequest_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			doneIrqEnable_reg <= 1'b0;
		end else if (wr_hit(ADDR_IRQ_EN)) begin
			doneIrqEnable_reg <= pwdata[0];
		end
	end

	// ----------------------------------------
	// software-written control
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			speedSelect_reg <= SETUP_RESET[SETUP_SPEED_BIT];
			triggerEnable_reg <= SETUP_RESET[SETUP_TRIGEN_BIT];
			inputSelect_reg <= SETUP_RESET[3:0];
		end else if (wr_hit(ADDR_SETUP)) begin
			speedSelect_reg <= pwdata[SETUP_SPEED_BIT];
			triggerEnable_reg <= pwdata[SETUP_TRIGEN_BIT];
			inputSelect_reg <= pwdata[3:0];
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			clockStop_reg <= CLOCK_STOP_RESET;
		end else if (wr_hit(ADDR_CLOCK_STOP)) begin
			// only bits 5..0 hold; 7 and 6 stay 1
			clockStop_reg <= {2'b11, pwdata[5:0]};
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			triggerEdge_reg <= 1'b0;
			triggerPinFunc_reg <= 1'b0;
		end else if (wr_hit(ADDR_TRIG_CTRL)) begin
			triggerEdge_reg <= pwdata[TRIG_EDGE_BIT];
			triggerPinFunc_reg <= pwdata[TRIG_PINFUNC_BIT];
		end
	end

	// ----------------------------------------
	// read data and converter-side outputs
	// ----------------------------------------
	logic [7:0] rdByte;
	always_comb begin
		case (paddr)
			ADDR_RESULT_HIGH: rdByte = result_reg[RES_BITS-1:2];
			ADDR_RESULT_LOW: rdByte = {result_reg[1:0], 6'h00};
			ADDR_SETUP: rdByte = {speedSelect_reg, triggerEnable_reg, 2'b00, inputSelect_reg}
				| SETUP_RSVD_MASK;
			ADDR_START: rdByte = {conversionActive_reg, 7'h00} | START_RSVD_ONES;
			ADDR_CLOCK_STOP: rdByte = clockStop_reg;
			ADDR_TRIG_CTRL: rdByte = {6'h00, triggerPinFunc_reg, triggerEdge_reg};
			ADDR_REQ_FLAGS: rdByte = {7'h00, doneRequest_reg};
			ADDR_IRQ_EN: rdByte = {7'h00, doneIrqEnable_reg};
			default: rdByte = 8'h00;
		endcase
	end

	logic knownAddr;
	assign knownAddr = (paddr[1:0] == 2'b00) && (paddr <= ADDR_IRQ_EN);

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			prdata <= '0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			// answer one cycle into the access phase
			pready <= psel && penable && !pready;
			pslverr <= psel && penable && !pready && !knownAddr;
			if (rdEn) begin
				prdata <= {24'h000000, rdByte};
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			inputSelect <= SETUP_RESET[3:0];
			channelValid <= 1'b0;
			sampling <= 1'b0;
			dacTrial <= '0;
			converterStandby <= 1'b0;
			convDoneIrq <= 1'b0;
		end else begin
			inputSelect <= inputSelect_reg;
			channelValid <= select_valid(inputSelect_reg);
			sampling <= (state_reg == ADCCT_CONV) && (cycleCount_reg < stepLen);
			dacTrial <= sarTrial;
			converterStandby <= !standbyRun;
			convDoneIrq <= doneRequest_reg && doneIrqEnable_reg;
		end
	end
endmodule
`default_nettype wire

// ===== adcctl_pkg.sv
package adcctl_pkg;
	// ----------------------------------------
	// register byte addresses
	// ----------------------------------------
	localparam logic [11:0] ADDR_RESULT_HIGH = 12'h000;
	localparam logic [11:0] ADDR_RESULT_LOW = 12'h004;
	localparam logic [11:0] ADDR_SETUP = 12'h008;
	localparam logic [11:0] ADDR_START = 12'h00C;
	localparam logic [11:0] ADDR_CLOCK_STOP = 12'h010;
	localparam logic [11:0] ADDR_TRIG_CTRL = 12'h014;
	localparam logic [11:0] ADDR_REQ_FLAGS = 12'h018;
	localparam logic [11:0] ADDR_IRQ_EN = 12'h01C;

	// ----------------------------------------
	// field positions and reset values
	// ----------------------------------------
	localparam int SETUP_SPEED_BIT = 7;
	localparam int SETUP_TRIGEN_BIT = 6;
	localparam int START_ACTIVE_BIT = 7;
	localparam int STOP_STANDBY_BIT = 4;
	localparam int TRIG_EDGE_BIT = 0;
	localparam int TRIG_PINFUNC_BIT = 1;
	localparam logic [7:0] SETUP_RESET = 8'h30;
	localparam logic [7:0] SETUP_RSVD_MASK = 8'h30;
	localparam logic [7:0] START_RSVD_ONES = 8'h7F;
	localparam logic [7:0] CLOCK_STOP_RESET = 8'hFF;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CONV_SLOW_CYCLES = 62;
	localparam int CONV_FAST_CYCLES = 31;
	localparam int RESULT_BITS = 10;
	localparam real MIN_CONV_TIME_US = 6.2;

	typedef enum logic [1:0] {
		ADCCT_IDLE = 2'b00,
		ADCCT_CONV = 2'b01
	} adcct_state_t;
endpackage

// ===== adcct_sar.sv
`timescale 1ns/1ps
`default_nettype none
// successive-approximation register: one decision per step, msb first
module adcct_sar
	import adcctl_pkg::*;
#(
	parameter int WIDTH = RESULT_BITS
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic begin_,
	input wire logic stepEn,
	input wire logic compHigh,
	output logic [WIDTH-1:0] trial,
	output logic lastStep
);
	logic [WIDTH-1:0] mask_reg;

	initial begin
		if (WIDTH < 2 || WIDTH > 16) $error("adcct_sar: WIDTH out of range");
	end

	assign lastStep = mask_reg[0];

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			mask_reg <= '0;
			trial <= '0;
		end else if (begin_) begin
			mask_reg <= {1'b1, {(WIDTH-1){1'b0}}};
			trial <= {1'b1, {(WIDTH-1){1'b0}}};
		end else if (stepEn && mask_reg != '0) begin
			// keep the trial bit if the input sits at or above it
			trial <= (compHigh ? trial : (trial & ~mask_reg)) | (mask_reg >> 1);
			mask_reg <= mask_reg >> 1;
		end
	end
endmodule
`default_nettype wire

// ===== adcct_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module adcct_checker
	import adcctl_pkg::*;
#(
	parameter int RES_BITS = RESULT_BITS
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic triggerPin,
	input wire logic compHigh,
	input wire logic [3:0] inputSelect,
	input wire logic channelValid,
	input wire logic sampling,
	input wire logic [RES_BITS-1:0] dacTrial,
	input wire logic converterStandby,
	input wire logic convDoneIrq
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	// ----
	// bus steps
	// ----
	sequence s_first_access;
		psel && penable && !pready;
	endsequence
	sequence s_stby_write;
		s_first_access ##0 (pwrite && paddr == ADDR_CLOCK_STOP);
	endsequence
	a_ready_answer: assert property (s_first_access |=> pready)
		else $error("no answer one cycle after access");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("ready held too long");
	a_err_only_ready: assert property (pslverr |-> pready)
		else $error("error without ready");
	a_unmapped_err: assert property (pready && paddr > ADDR_IRQ_EN |-> pslverr)
		else $error("unmapped access not refused");
	a_mapped_ok: assert property (pready && paddr <= ADDR_IRQ_EN && paddr[1:0] == 2'b00 |-> !pslverr)
		else $error("mapped access refused");
	a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h000000)
		else $error("upper read bits set");
	a_setup_rsvd: assert property (pready && !pwrite && paddr == ADDR_SETUP |-> prdata[5:4] == 2'b11)
		else $error("setup reserved bits not one");
	a_start_rsvd: assert property (pready && !pwrite && paddr == ADDR_START |-> prdata[6:0] == 7'h7F)
		else $error("start reserved bits not one");
	a_select_valid: assert property (channelValid == (inputSelect[3] ^ inputSelect[2]))
		else $error("channel valid wrong for select code");
	a_standby_write: assert property (s_stby_write |=> ##[0:1] (converterStandby != pwdata[4]))
		else $error("standby output does not follow write");
endmodule
`default_nettype wire

// ===== adcct_top_test.sv
`timescale 1ns/1ps
`default_nettype none
module adcct_top_test;
	import adcctl_pkg::*;
	logic clk = 0;
	logic reset_n = 0;
	logic psel = 0;
	logic penable = 0;
	logic pwrite = 0;
	logic triggerPin = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, channelValid, sampling, converterStandby, convDoneIrq, err;
	logic [3:0] inputSelect;
	logic [9:0] dacTrial;
	logic [9:0] target = 10'h2B5;
	// ideal comparator: analog side answers at once
	wire compHigh = (target >= dacTrial);
	int failures = 0;
	int n_checks = 0;
	adcct_top i_adcct_top (.clk(clk), .reset_n(reset_n), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .triggerPin(triggerPin), .compHigh(compHigh),
		.inputSelect(inputSelect), .channelValid(channelValid), .sampling(sampling),
		.dacTrial(dacTrial), .converterStandby(converterStandby), .convDoneIrq(convDoneIrq));
	initial forever #25 clk = ~clk;
	// ----
	// bus and compare tasks
	// ----
	task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
		int k;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		// request held until ready is seen at this rising edge
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task chk(input string s, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			$display("unexpected %s expected %h seen %h", s, e, g);
			failures++;
		end
	endtask
	task bchk(input string s, input logic e, input logic g);
		chk(s, {31'h0, e}, {31'h0, g});
	endtask
	task rchk(input string s, input logic [11:0] a, input logic [31:0] e);
		xfer(a, 1'b0, 32'h0);
		chk(s, e, rd);
	endtask
	task automatic conv(input logic sp, input int per);
		int k;
		xfer(ADDR_SETUP, 1'b1, {24'h0, sp, 7'h04});
		@(negedge clk);
		chk("input_select", 32'h4, {28'h0, inputSelect});
		xfer(ADDR_START, 1'b1, 32'h80);
		@(negedge clk);
		bchk("sampling", 1'b1, sampling);
		for (k = 0; k < 200 && convDoneIrq !== 1'b1; k++) @(negedge clk);
		bchk("period", 1'b1, k >= per - 2 && k <= per + 4);
		rchk("result_high", ADDR_RESULT_HIGH, {24'h0, target[9:2]});
		xfer(ADDR_RESULT_LOW, 1'b0, 32'h0);
		chk("result_low", {30'h0, target[1:0]}, {30'h0, rd[7:6]});
		chk("dac_trial", {22'h0, target}, {22'h0, dacTrial});
		rchk("start", ADDR_START, 32'h7F);
	endtask
	task report_and_stop;
		if (failures == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge clk);
		failures++;
		report_and_stop;
	end
	// ----
	// scenarios
	// ----
	initial begin
		repeat (5) @(posedge clk);
		reset_n <= 1'b1;
		rchk("setup", ADDR_SETUP, 32'h30);
		rchk("start", ADDR_START, 32'h7F);
		rchk("clock_stop", ADDR_CLOCK_STOP, 32'hFF);
		for (int i = 0; i < 16; i++) begin
			xfer(ADDR_SETUP, 1'b1, i);
			@(negedge clk);
			bchk("valid", i[3] ^ i[2], channelValid);
		end
		rchk("setup", ADDR_SETUP, 32'h3F);
		xfer(ADDR_IRQ_EN, 1'b1, 32'h1);
		conv(1'b0, 62);
		xfer(ADDR_REQ_FLAGS, 1'b0, 32'h0);
		bchk("done_flag", 1'b1, rd[0]);
		xfer(ADDR_REQ_FLAGS, 1'b1, 32'h0);
		@(negedge clk);
		bchk("irq", 1'b0, convDoneIrq);
		target <= 10'h16A;
		conv(1'b1, 31);
		xfer(ADDR_REQ_FLAGS, 1'b1, 32'h0);
		xfer(ADDR_IRQ_EN, 1'b1, 32'h0);
		xfer(ADDR_START, 1'b1, 32'h80);
		xfer(ADDR_START, 1'b1, 32'h00);
		rchk("start", ADDR_START, 32'h7F);
		repeat (80) @(negedge clk);
		xfer(ADDR_REQ_FLAGS, 1'b0, 32'h0);
		bchk("done_flag", 1'b0, rd[0]);
		rchk("result_high", ADDR_RESULT_HIGH, {24'h0, target[9:2]});
		xfer(ADDR_TRIG_CTRL, 1'b1, 32'h3);
		xfer(ADDR_SETUP, 1'b1, 32'h04);
		triggerPin <= 1'b1;
		repeat (4) @(posedge clk);
		rchk("start", ADDR_START, 32'h7F);
		triggerPin <= 1'b0;
		xfer(ADDR_SETUP, 1'b1, 32'h44);
		triggerPin <= 1'b1;
		repeat (4) @(posedge clk);
		rchk("start", ADDR_START, 32'hFF);
		repeat (80) @(negedge clk);
		xfer(ADDR_REQ_FLAGS, 1'b0, 32'h0);
		bchk("irq_masked", 1'b0, convDoneIrq);
		bchk("done_flag", 1'b1, rd[0]);
		xfer(ADDR_CLOCK_STOP, 1'b1, 32'hEF);
		@(negedge clk);
		bchk("standby", 1'b1, converterStandby);
		xfer(ADDR_START, 1'b1, 32'h80);
		rchk("start", ADDR_START, 32'h7F);
		xfer(ADDR_CLOCK_STOP, 1'b1, 32'hFF);
		rchk("unmapped", 12'h020, 32'h0);
		bchk("pslverr", 1'b1, err);
		reset_n <= 1'b0;
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		rchk("result_high", ADDR_RESULT_HIGH, {24'h0, target[9:2]});
		rchk("setup", ADDR_SETUP, 32'h30);
		report_and_stop;
	end
endmodule
bind adcct_top adcct_checker #(.RES_BITS(RES_BITS)) i_adcct_checker (.clk(clk),
	.reset_n(reset_n), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.triggerPin(triggerPin), .compHigh(compHigh), .inputSelect(inputSelect),
	.channelValid(channelValid), .sampling(sampling), .dacTrial(dacTrial),
	.converterStandby(converterStandby), .convDoneIrq(convDoneIrq));
`default_nettype wire
